// ===== design/tsi_map.svh
`ifndef TSI_MAP_SVH
`define TSI_MAP_SVH

// register offsets on the AXI4-Lite slave (byte addresses)
`define TSI_CTRL_OFF 8'h00
`define TSI_STAT_OFF 8'h04

// control register fields and reset value
`define TSI_CTRL_RATE_LSB 0
`define TSI_CTRL_RATE_MSB 1
`define TSI_CTRL_SB_BIT 2
`define TSI_CTRL_SPLIT_BIT 3
`define TSI_CTRL_RESET 4'h0

// status register fields
`define TSI_STAT_WIDE_BIT 0
`define TSI_STAT_MUX_BIT 1
`define TSI_STAT_DRST_BIT 2
`define TSI_STAT_TAPRST_BIT 3
`define TSI_STAT_BUSY_BIT 4
`define TSI_STAT_BCNT_LSB 16

// AXI response codes
`define TSI_RESP_OKAY 2'b00
`define TSI_RESP_SLVERR 2'b10

// host memory: address bit 7 picks the high-impedance half
`define TSI_HIZ_SEL_BIT 7

// serial rates and the phase increments derived from the 200 MHz clock
`define TSI_CLK_HZ 64'd200000000
`define TSI_RATE_4M_BPS 64'd4096000
`define TSI_RATE_8M_BPS 64'd8192000
`define TSI_RATE_16M_BPS 64'd16384000
`define TSI_PHASE_INC(r) (((r) << 32) / `TSI_CLK_HZ)

// last bit index of a frame: 512, 1024 or 2048 bits
`define TSI_LAST_BIT_4M 11'd511
`define TSI_LAST_BIT_8M 11'd1023
`define TSI_LAST_BIT_16M 11'd2047

`endif

// ===== design/tsi_pkg.sv
package tsi_pkg;

    // host port access sequence, gray coded along idle -> ack -> release
    typedef enum logic [1:0] {
        TSI_HP_IDLE = 2'b00,
        TSI_HP_ACK = 2'b01,
        TSI_HP_REL = 2'b11
    } tsi_hp_state_e;

    // serial rate select
    typedef enum logic [1:0] {
        TSI_RATE_4M = 2'b00,
        TSI_RATE_8M = 2'b01,
        TSI_RATE_16M = 2'b10
    } tsi_rate_e;

    typedef logic [15:0] tsi_word_t;

endpackage : tsi_pkg

// ===== design/tsi_host_port.sv
// Operation
// - device reset low clears counters and registers, floats serial and host data outputs
// - test reset low forces test controller into its reset state asynchronously
// - wide pulse select high uses wide frame alignment, low uses narrow pulse
// - multiplex select high shares address and data, low keeps them apart
// - non-multiplexed accesses take address from the eight dedicated address lines
// - multiplexed: low byte lines carry address too, high byte only upper data
// - multiplexed strobe-and-direction bus: data strobe is active high
// - non-multiplexed strobe-and-direction bus: data strobe active low with port select
// - direction input decides whether data lines are driven or received
// - split bus: data lines driven while read strobe is low
// - split bus: low byte lines are inputs while write strobe is low
// - host port answers only while port select is low
// - address latch strobe used only in multiplexed mode, grounded otherwise
// - acknowledge low marks transfer done, then driven high, then released
// - control serial output at 4/8/16 Mb/s, 512/1024/2048 bits, from memory bits
// - drive enable low with standby low floats transmit outputs, high enables them
// - per-channel high-impedance bit floats that output for its slot
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`include "tsi_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tsi_host_port
    import tsi_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // device pins
    input wire logic device_reset_n_i,
    input wire logic test_reset_n_i,
    output logic tap_logic_reset_o,
    input wire logic wide_pulse_select_i,
    input wire logic frame_pulse_n_i,
    input wire logic bus_multiplex_select_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] shared_low_byte_bus_i,
    output logic [7:0] shared_low_byte_bus_o,
    output logic shared_low_byte_bus_oe_o,
    input wire logic [7:0] high_byte_bus_i,
    output logic [7:0] high_byte_bus_o,
    output logic high_byte_bus_oe_o,
    input wire logic data_strobe_in_i,
    input wire logic read_write_i,
    input wire logic port_select_n_i,
    input wire logic address_latch_strobe_i,
    output logic transfer_ack_n_o,
    output logic transfer_ack_n_oe_o,
    output logic channel_control_serial_out_o,
    input wire logic output_drive_enable_in_i,
    input wire logic [15:0] tx_data_i,
    output logic [15:0] serial_transmit_outputs_o,
    output logic [15:0] serial_transmit_outputs_oe_o
);

    // ---------------- state ----------------
    logic [3:0] ctrl_q;
    tsi_hp_state_e hp_state_q, hp_state_d;
    logic [7:0] addr_lat_q;
    logic ale_q;
    logic fp_q;
    tsi_word_t rd_q;
    tsi_word_t mem_q [256];
    logic [31:0] phase_q;
    logic [10:0] bit_cnt_q;
    logic cco_q;
    logic [15:0] tx_q;
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // ---------------- decode ----------------
    wire clr = ~rst_n_i | ~device_reset_n_i;
    wire mux_mode = bus_multiplex_select_i;
    wire split_mode = mux_mode & ctrl_q[`TSI_CTRL_SPLIT_BIT];
    wire standby = ctrl_q[`TSI_CTRL_SB_BIT];
    wire [1:0] rate_sel = ctrl_q[`TSI_CTRL_RATE_MSB:`TSI_CTRL_RATE_LSB];
    wire port_sel = ~port_select_n_i & device_reset_n_i;
    // strobe sense depends on bus flavour
    wire ds_on = mux_mode ? data_strobe_in_i : ~data_strobe_in_i;
    wire split_rd = ~data_strobe_in_i;
    wire split_wr = ~read_write_i;
    wire acc_act = port_sel & (split_mode ? (split_rd | split_wr) : ds_on);
    // split bus reads on its own strobe, the others follow the direction pin
    wire acc_read = split_mode ? split_rd : read_write_i;
    // address source: latched copy of the shared lines, or the dedicated lines
    wire [7:0] hp_addr = mux_mode ? addr_lat_q : addr_i;
    wire hp_start = (hp_state_q == TSI_HP_IDLE) & acc_act;
    wire wr_go = hp_start & ~acc_read;
    wire tsi_word_t wr_word = {high_byte_bus_i, shared_low_byte_bus_i};
    // latch strobe is high while address is valid; capture as it drops
    wire ale_fall = mux_mode & ale_q & ~address_latch_strobe_i;

    // ---------------- host access sequence ----------------
    always_comb begin
        hp_state_d = hp_state_q;
        case (hp_state_q)
            TSI_HP_IDLE: begin
                if (acc_act) begin
                    hp_state_d = TSI_HP_ACK;
                end
            end
            TSI_HP_ACK: begin
                if (!acc_act) begin
                    hp_state_d = TSI_HP_REL;
                end
            end
            TSI_HP_REL: hp_state_d = TSI_HP_IDLE;
            default: hp_state_d = TSI_HP_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (clr) begin
            hp_state_q <= TSI_HP_IDLE;
        end else begin
            hp_state_q <= hp_state_d;
        end
    end

    // address latch; the edge detector reads the pin directly since pins are synchronous
    always_ff @(posedge clk_i) begin
        if (clr) begin
            ale_q <= 1'b0;
            addr_lat_q <= 8'h00;
        end else begin
            ale_q <= address_latch_strobe_i;
            if (ale_fall) begin
                addr_lat_q <= shared_low_byte_bus_i;
            end
        end
    end

    // host memory: low half holds control-output bits, high half the float bits
    always_ff @(posedge clk_i) begin
        if (clr) begin
            for (int i = 0; i < 256; i++) begin
                mem_q[i] <= 16'h0000;
            end
            rd_q <= 16'h0000;
        end else begin
            if (wr_go) begin
                mem_q[hp_addr] <= wr_word;
            end
            if (hp_start) begin
                rd_q <= mem_q[hp_addr];
            end
        end
    end

    // data lines turn round only inside the acknowledged phase of a read
    wire data_drive = (hp_state_q == TSI_HP_ACK) & acc_act & acc_read;
    assign shared_low_byte_bus_o = rd_q[7:0];
    assign high_byte_bus_o = rd_q[15:8];
    assign shared_low_byte_bus_oe_o = data_drive;
    assign high_byte_bus_oe_o = data_drive;
    // acknowledge: low while acked, high for one cycle after, then floated
    assign transfer_ack_n_o = (hp_state_q != TSI_HP_ACK);
    assign transfer_ack_n_oe_o = (hp_state_q != TSI_HP_IDLE);
    // test controller lives on its own clock; its reset is a pure gate, no clock needed
    assign tap_logic_reset_o = ~test_reset_n_i;

    // ---------------- serial timing ----------------
    wire [31:0] inc_4m = 32'(`TSI_PHASE_INC(`TSI_RATE_4M_BPS));
    wire [31:0] inc_8m = 32'(`TSI_PHASE_INC(`TSI_RATE_8M_BPS));
    wire [31:0] inc_16m = 32'(`TSI_PHASE_INC(`TSI_RATE_16M_BPS));
    // fractional divider: 200 MHz is no integer multiple of these rates, so jitter of one cycle
    wire [31:0] phase_inc = (rate_sel == TSI_RATE_8M) ? inc_8m :
                            (rate_sel == TSI_RATE_16M) ? inc_16m : inc_4m;
    wire [10:0] last_bit = (rate_sel == TSI_RATE_8M) ? `TSI_LAST_BIT_8M :
                           (rate_sel == TSI_RATE_16M) ? `TSI_LAST_BIT_16M : `TSI_LAST_BIT_4M;
    wire [32:0] phase_sum = {1'b0, phase_q} + {1'b0, phase_inc};
    wire bit_en = phase_sum[32];
    // narrow pulse starts a frame on its falling edge, wide pulse on its rising edge
    wire frame_start = wide_pulse_select_i ? (~fp_q & frame_pulse_n_i)
                                           : (fp_q & ~frame_pulse_n_i);
    wire [6:0] chan = bit_cnt_q[10:4];
    wire [3:0] strm = bit_cnt_q[3:0];
    wire [7:0] cco_idx = {1'b0, chan};
    wire [7:0] hiz_idx = {1'b1, chan};
    wire [15:0] hiz_word = mem_q[hiz_idx];
    wire cco_next = mem_q[cco_idx][strm];

    always_ff @(posedge clk_i) begin
        if (clr) begin
            phase_q <= 32'h0000_0000;
            bit_cnt_q <= 11'h000;
            fp_q <= 1'b1;
            cco_q <= 1'b0;
            tx_q <= 16'h0000;
        end else begin
            fp_q <= frame_pulse_n_i;
            tx_q <= tx_data_i;
            if (frame_start) begin
                phase_q <= 32'h0000_0000;
                bit_cnt_q <= 11'h000;
            end else begin
                phase_q <= phase_sum[31:0];
                if (bit_en) begin
                    bit_cnt_q <= (bit_cnt_q >= last_bit) ? 11'h000 : bit_cnt_q + 11'h001;
                    cco_q <= cco_next;
                end
            end
        end
    end

    // global enable (pin or standby bit), minus channels marked floating
    wire tx_global_en = (output_drive_enable_in_i | standby) & device_reset_n_i;
    assign serial_transmit_outputs_o = tx_q;
    assign serial_transmit_outputs_oe_o = {16{tx_global_en}} & ~hiz_word;
    assign channel_control_serial_out_o = cco_q;

    // ---------------- AXI4-Lite slave ----------------
    // address and data are parked independently so either may come first
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    wire wr_ctrl = wr_fire & (aw_addr_q == `TSI_CTRL_OFF);
    wire wr_ok = (aw_addr_q == `TSI_CTRL_OFF) | (aw_addr_q == `TSI_STAT_OFF);
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire [31:0] stat_word;
    assign stat_word = {5'h00, bit_cnt_q, 11'h000, hp_state_q != TSI_HP_IDLE,
                        ~test_reset_n_i, ~device_reset_n_i, mux_mode, wide_pulse_select_i};
    wire rd_hit_ctrl = (s_axi_araddr == `TSI_CTRL_OFF);
    wire rd_hit_stat = (s_axi_araddr == `TSI_STAT_OFF);
    wire [31:0] rd_mux = rd_hit_ctrl ? {28'h0000000, ctrl_q} :
                         rd_hit_stat ? stat_word : 32'h0000_0000;
    assign s_axi_awready = ~aw_hold_q;
    assign s_axi_wready = ~w_hold_q;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TSI_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `TSI_RESP_OKAY : `TSI_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control register is cleared by either reset, as the device reset clears all registers
    always_ff @(posedge clk_i) begin
        if (clr) begin
            ctrl_q <= `TSI_CTRL_RESET;
        end else if (wr_ctrl && w_strb_q[0]) begin
            ctrl_q <= w_data_q[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TSI_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= (rd_hit_ctrl | rd_hit_stat) ? `TSI_RESP_OKAY : `TSI_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_reset_floats_pins: assert property (!device_reset_n_i
        |-> ~|serial_transmit_outputs_oe_o && !shared_low_byte_bus_oe_o && !high_byte_bus_oe_o)
        else $error("outputs driven during device reset");
    a_reset_clears_count: assert property (!device_reset_n_i |=> bit_cnt_q == 11'h000
        && ctrl_q == `TSI_CTRL_RESET)
        else $error("device reset left state behind");
    a_tap_reset_forced: assert property (!test_reset_n_i |-> tap_logic_reset_o)
        else $error("test reset not forced");
    a_wide_frame_align: assert property (wide_pulse_select_i && device_reset_n_i
        && !fp_q && frame_pulse_n_i |=> bit_cnt_q == 11'h000)
        else $error("wide pulse edge did not align frame");
    a_narrow_frame_align: assert property (!wide_pulse_select_i && device_reset_n_i
        && fp_q && !frame_pulse_n_i |=> bit_cnt_q == 11'h000)
        else $error("narrow pulse edge did not align frame");
    a_nonmux_addr_lines: assert property (!mux_mode && wr_go ##1 1
        |-> mem_q[$past(addr_i)] == $past(wr_word))
        else $error("non-multiplexed write missed address lines");
    a_latch_holds_addr: assert property (ale_fall && device_reset_n_i
        |=> addr_lat_q == $past(shared_low_byte_bus_i)
        ##1 (ale_fall || addr_lat_q == $past(addr_lat_q)))
        else $error("latched address wrong or not held");
    a_mux_ds_active_high: assert property (mux_mode && !split_mode && port_sel
        && data_strobe_in_i && hp_state_q == TSI_HP_IDLE |=> hp_state_q == TSI_HP_ACK)
        else $error("high data strobe not accepted");
    a_nonmux_ds_active_low: assert property (!mux_mode && port_sel && !data_strobe_in_i
        && hp_state_q == TSI_HP_IDLE |=> hp_state_q == TSI_HP_ACK)
        else $error("low data strobe not accepted");
    a_dir_write_no_drive: assert property (!split_mode && !read_write_i
        |-> !shared_low_byte_bus_oe_o && !high_byte_bus_oe_o)
        else $error("bus driven during write direction");
    a_split_read_drives: assert property (split_mode && port_sel && !data_strobe_in_i
        && hp_state_q == TSI_HP_ACK |-> shared_low_byte_bus_oe_o && high_byte_bus_oe_o)
        else $error("split read not driving bus");
    a_split_write_input: assert property (split_mode && data_strobe_in_i
        && !read_write_i |-> !shared_low_byte_bus_oe_o)
        else $error("split write drove low byte");
    a_select_gates_port: assert property (port_select_n_i && hp_state_q == TSI_HP_IDLE
        |=> hp_state_q == TSI_HP_IDLE && transfer_ack_n_oe_o == 1'b0)
        else $error("port answered without select");
    a_ack_release_seq: assert property (hp_state_q == TSI_HP_ACK && !acc_act
        && device_reset_n_i |-> !transfer_ack_n_o ##1 (transfer_ack_n_o && transfer_ack_n_oe_o)
        ##1 !transfer_ack_n_oe_o)
        else $error("acknowledge did not drive high then release");
    a_cco_frame_wrap: assert property (bit_en && !frame_start && bit_cnt_q == last_bit
        && device_reset_n_i |=> bit_cnt_q == 11'h000)
        else $error("control frame length wrong");
    a_drive_disable: assert property (!output_drive_enable_in_i && !standby
        |-> serial_transmit_outputs_oe_o == 16'h0000)
        else $error("transmit driven with drive enable low");
    a_slot_float: assert property ((serial_transmit_outputs_oe_o & hiz_word) == 16'h0000)
        else $error("floating channel driven");

    c_split_read: cover property (split_mode && data_drive);
    c_mux_write: cover property (mux_mode && !split_mode && wr_go);
    c_wide_frame: cover property (wide_pulse_select_i && frame_start);
    c_axi_ctrl_write: cover property (wr_ctrl);

endmodule : tsi_host_port

`default_nettype wire

// ===== bench/tsi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host processor on the parallel port; it owns select, strobes, address and write data
module tsi_host_model (
    input wire logic clk_i,
    input wire logic ack_n_i,
    input wire logic [7:0] lo_i,
    input wire logic [7:0] hi_i,
    output logic cs_n_o,
    output logic ds_o,
    output logic rw_o,
    output logic ale_o,
    output logic [7:0] addr_o,
    output logic [7:0] lo_o,
    output logic [7:0] hi_o
);
    // idle bus: nothing selected, strobes inactive for the non-multiplexed variant
    initial begin
        {cs_n_o, ds_o, rw_o, ale_o} = 4'b1110;
        {addr_o, lo_o, hi_o} = '0;
    end

    // one access: latch phase in multiplexed mode, then strobe until the acknowledge
    task automatic access(input bit mux, split, rd, input logic [7:0] a, input logic [15:0] wd,
                          output logic [15:0] rdat, output bit ok);
        int i;
        ok = 0;
        rdat = '0;
        @(posedge clk_i);
        if (mux) begin
            ale_o <= 1'b1;
            lo_o <= a;
            @(posedge clk_i);
            ale_o <= 1'b0;
            @(posedge clk_i);
        end
        addr_o <= mux ? ~a : a;
        cs_n_o <= 1'b0;
        rw_o <= rd;
        ds_o <= split ? !rd : mux;
        {hi_o, lo_o} <= wd;
        for (i = 0; i < 20 && !ok; i++) begin
            @(posedge clk_i);
            if (ack_n_i === 1'b0) begin
                ok = 1;
                rdat = {hi_i, lo_i};
            end
        end
        // release; undriven lines show the inverse of the last value, never a stale copy
        cs_n_o <= 1'b1;
        ds_o <= !(mux && !split);
        rw_o <= 1'b1;
        {hi_o, lo_o} <= ~wd;
        repeat (3) @(posedge clk_i);
    endtask : access
endmodule : tsi_host_model
`default_nettype wire

// ===== bench/tsi_host_port_and_output_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsi_map.svh"
module tsi_host_port_and_output_control_bench;
    localparam logic [7:0] ctrl_a = `TSI_CTRL_OFF;
    localparam logic [7:0] stat_a = `TSI_STAT_OFF;
    localparam logic [1:0] okay = `TSI_RESP_OKAY;
    localparam logic [1:0] slverr = `TSI_RESP_SLVERR;
    logic clk_i, rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr, shared_low_byte_bus_o, high_byte_bus_o, addr_i;
    logic [7:0] h_lo, h_hi;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic device_reset_n_i, test_reset_n_i, tap_logic_reset_o, wide_pulse_select_i;
    logic frame_pulse_n_i, bus_multiplex_select_i, shared_low_byte_bus_oe_o, high_byte_bus_oe_o;
    logic data_strobe_in_i, read_write_i, port_select_n_i, address_latch_strobe_i;
    logic transfer_ack_n_o, transfer_ack_n_oe_o, channel_control_serial_out_o;
    logic output_drive_enable_in_i;
    logic [15:0] tx_data_i, serial_transmit_outputs_o, serial_transmit_outputs_oe_o, hd;
    wire logic [7:0] shared_low_byte_bus_i =
        shared_low_byte_bus_oe_o ? shared_low_byte_bus_o : h_lo;
    wire logic [7:0] high_byte_bus_i = high_byte_bus_oe_o ? high_byte_bus_o : h_hi;
    wire logic ack_n = transfer_ack_n_oe_o ? transfer_ack_n_o : 1'b1; // pull-up when released
    int err_count, tests_run, cyc, i, r, t0, c0, d, e;
    bit ok;

    tsi_host_port uut (.*);
    tsi_host_model host (.clk_i, .ack_n_i(ack_n), .lo_i(shared_low_byte_bus_i),
        .hi_i(high_byte_bus_i), .cs_n_o(port_select_n_i), .ds_o(data_strobe_in_i),
        .rw_o(read_write_i), .ale_o(address_latch_strobe_i), .addr_o(addr_i), .lo_o(h_lo),
        .hi_o(h_hi));

    // 200 MHz clock and a cycle count for rate checks
    initial begin
        clk_i = 0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc <= cyc + 1;

    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask : chk

    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task hang(input string n);
        chk(n, 0, 1);
        print_verdict();
    endtask : hang

    // AXI write: address and data offered together, each dropped once taken
    task axi_wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
        @(posedge clk_i);
        {s_axi_awaddr, s_axi_wdata} <= {a, dt};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (i = 0; i < 40; i++) begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (i == 40) hang("bvalid");
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask : axi_wr

    // AXI read; a masked compare lets status fields be checked one by one
    task axi_rd(input logic [7:0] a, input logic [31:0] m, x, input logic [1:0] er);
        @(posedge clk_i);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (i = 0; i < 40; i++) begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (i == 40) hang("rvalid");
        rv = s_axi_rdata;
        chk("rdata", rv & m, x);
        chk("rresp", 32'(s_axi_rresp), 32'(er));
    endtask : axi_rd

    // parallel port access; the acknowledge must come and then let go of the line
    task hacc(input bit mux, split, rd, input logic [7:0] a, input logic [15:0] wd, x);
        host.access(mux, split, rd, a, wd, hd, ok);
        if (!ok) hang("ack");
        if (rd) chk("host data", 32'(hd), 32'(x));
        chk("ack released", 32'(transfer_ack_n_oe_o), 0);
    endtask : hacc

    initial begin
        rst_n_i = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {device_reset_n_i, test_reset_n_i, wide_pulse_select_i, frame_pulse_n_i} = 4'b1101;
        {bus_multiplex_select_i, output_drive_enable_in_i} = 2'b00;
        tx_data_i = 16'ha5c3;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1;
        // reset state, registers and refused addresses
        chk("tx oe", 32'(serial_transmit_outputs_oe_o), 0);
        chk("data oe", 32'(shared_low_byte_bus_oe_o), 0);
        axi_rd(ctrl_a, 32'hf, 0, okay);
        axi_rd(stat_a, 32'h1f, 0, okay);
        axi_wr(8'h40, 1, slverr);
        axi_rd(8'h40, 32'hffffffff, 0, slverr);
        axi_wr(stat_a, 32'hffff, okay);
        axi_rd(stat_a, 32'hf, 0, okay);
        // non-multiplexed, multiplexed and split variants, back to back
        hacc(0, 0, 0, 8'h05, 16'hbeef, 0);
        hacc(0, 0, 1, 8'h05, 0, 16'hbeef);
        bus_multiplex_select_i <= 1;
        axi_rd(stat_a, 32'h2, 32'h2, okay);
        hacc(1, 0, 0, 8'h10, 16'h1234, 0);
        hacc(1, 0, 1, 8'h05, 0, 16'hbeef);
        hacc(1, 0, 1, 8'h10, 0, 16'h1234);
        axi_wr(ctrl_a, 8, okay);
        hacc(1, 1, 0, 8'h06, 16'h0f0f, 0);
        hacc(1, 1, 1, 8'h06, 0, 16'h0f0f);
        axi_wr(ctrl_a, 0, okay);
        bus_multiplex_select_i <= 0;
        // drive enable pin, then the standby bit alone
        output_drive_enable_in_i <= 1;
        repeat (2) @(posedge clk_i);
        chk("tx oe", 32'(serial_transmit_outputs_oe_o), 32'hffff);
        chk("tx data", 32'(serial_transmit_outputs_o), 32'ha5c3);
        // device reset floats the transmit outputs even with drivers enabled; held past the board minimum
        device_reset_n_i <= 0;
        repeat (20) @(posedge clk_i);
        chk("tx oe", 32'(serial_transmit_outputs_oe_o), 0);
        axi_rd(stat_a, 32'h4, 32'h4, okay);
        device_reset_n_i <= 1;
        hacc(0, 0, 1, 8'h05, 0, 0);
        output_drive_enable_in_i <= 0;
        axi_wr(ctrl_a, 4, okay);
        chk("tx oe", 32'(serial_transmit_outputs_oe_o), 32'hffff);
        axi_wr(ctrl_a, 0, okay);
        chk("tx oe", 32'(serial_transmit_outputs_oe_o), 0);
        // test reset reaches the test controller without a clock
        test_reset_n_i <= 0;
        @(posedge clk_i);
        #1 chk("tap reset", 32'(tap_logic_reset_o), 1);
        axi_rd(stat_a, 32'h8, 32'h8, okay);
        test_reset_n_i <= 1;
        // bit counter advances at each of the three rates
        for (r = 0; r < 3; r++) begin
            axi_wr(ctrl_a, r, okay);
            axi_rd(stat_a, 0, 0, okay);
            t0 = cyc;
            c0 = rv[26:16];
            repeat (2000) @(posedge clk_i);
            axi_rd(stat_a, 0, 0, okay);
            d = (rv[26:16] - c0) & ((512 << r) - 1);
            e = (cyc - t0) * (4096 << r) / 200000;
            chk("bit count", 32'((d - e + 2) inside {[0:4]}), 1);
        end
        // frame edge restarts the count: falling when narrow, rising when wide
        frame_pulse_n_i <= 0;
        axi_rd(stat_a, 32'h07fe0000, 0, okay);
        wide_pulse_select_i <= 1;
        frame_pulse_n_i <= 1;
        axi_rd(stat_a, 32'h07fe0001, 1, okay);
        // one full frame at the top rate, so the counter must wrap at 2047
        t0 = cyc;
        repeat (25400) @(posedge clk_i);
        axi_rd(stat_a, 0, 0, okay);
        d = rv[26:16];
        e = ((cyc - t0) * 16384 / 200000) % 2048;
        chk("frame wrap", 32'((d - e + 2) inside {[0:4]}), 1);
        // control bits set and every channel floated
        output_drive_enable_in_i <= 1;
        for (r = 0; r < 128; r++) begin
            hacc(0, 0, 0, 8'(r), 16'hffff, 0);
            hacc(0, 0, 0, 8'(r + 128), 16'hffff, 0);
        end
        repeat (64) @(posedge clk_i);
        chk("control out", 32'(channel_control_serial_out_o), 1);
        chk("tx oe", 32'(serial_transmit_outputs_oe_o), 0);
        print_verdict();
    end
endmodule : tsi_host_port_and_output_control_bench
`default_nettype wire
